// File: hdl/cfp_pkg.sv
/*
  Constants and carrier types for the core sequencer: phase encoding,
  program memory vectors and sizes, data memory map, core register offsets.
  Assumes a single clock domain on sys_clk and an asynchronous active-low reset.
*/
// Operation
// RQ1: Input clock divided by four into four non-overlapping phases per cycle.
// RQ2: Program counter advances once per instruction cycle, in phase_one.
// RQ3: Instruction word read from program memory and captured in phase_four.
// RQ4: Fetch of next instruction overlaps execution of previous one.
// RQ5: Fetched word enters instruction_latch at phase_one, executes phases two to four.
// RQ6: Operand read in phase_two, destination written in phase_four.
// RQ7: Program counter changes take two cycles; fetched next word is flushed.
// RQ8: Program counter is 13 bits, 8K word space of 14-bit words.
// RQ9: Addresses above the implemented 512, 1K or 2K words wrap around.
// RQ10: Execution starts at 0000h after reset; interrupts vector to 0004h.
// RQ11: bank_select_bit, core flags bit 5, picks data bank 0 or 1.
// RQ12: Lowest 32 addresses of each bank hold special function registers.
// RQ13: RAM at 20-7Fh in bank 0; largest variant also A0-BFh in bank 1. The 80-byte variants stop at 6Fh in bank 0.
// RQ14: Later variants map bank 1 F0h-FFh onto bank 0 70h-7Fh.
// RQ15: General file of 80, 96 or 128 bytes, direct or via indirect_pointer.
// RQ16: instruction_rate_out runs at one quarter of the input clock in RC mode.
// RQ17: Unimplemented data locations read zero and ignore writes.
// RQ18: Core registers appear at the same offsets in both banks.
package cfp_pkg;

  localparam int PC_W = 13;
  localparam int INSN_W = 14;
  localparam int FA_W = 7;
  localparam int DA_W = 8;

  localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PMEM_MASK_512 = 13'h01FF;
  localparam logic [PC_W-1:0] PMEM_MASK_1K = 13'h03FF;
  localparam logic [PC_W-1:0] PMEM_MASK_2K = 13'h07FF;

  // Core register offsets within a bank
  localparam logic [FA_W-1:0] OFS_INDIRECT_PORT = 7'h00;
  localparam logic [FA_W-1:0] OFS_PC_LOW = 7'h02;
  localparam logic [FA_W-1:0] OFS_CORE_FLAGS = 7'h03;
  localparam logic [FA_W-1:0] OFS_INDIRECT_PTR = 7'h04;
  localparam logic [FA_W-1:0] OFS_PC_UPPER_LATCH = 7'h0A;
  localparam logic [FA_W-1:0] SFR_TOP = 7'h1F;
  localparam int BANK_SEL_BIT = 5;

  localparam logic [DA_W-1:0] GP0_LO = 8'h20;
  localparam logic [DA_W-1:0] GP0_HI = 8'h7F;
  localparam logic [DA_W-1:0] GP1_LO = 8'hA0;
  localparam logic [DA_W-1:0] GP1_HI = 8'hBF;
  localparam logic [DA_W-1:0] GP_PLAIN_TOP = 8'h6F;
  localparam logic [DA_W-1:0] COMMON_LO = 8'hF0;
  localparam logic [DA_W-1:0] SMALL_TOP = 8'h6F;
  localparam logic [DA_W-1:0] MID_TOP = 8'h7F;

  localparam logic [7:0] FLAGS_RESET = 8'h18;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam int GP_DEPTH = 160;

  // Variant select
  typedef enum logic [2:0] {
    CFP_V_512_80, CFP_V_1K_80, CFP_V_2K_128,
    CFP_V_512_96, CFP_V_1K_96, CFP_V_2K_128C
  } cfp_variant_t;

  typedef enum logic [1:0] {CFP_PHASE_ONE, CFP_PHASE_TWO, CFP_PHASE_THREE, CFP_PHASE_FOUR} cfp_phase_t;

  // Execute-side request from the decode logic
  typedef struct packed {
    logic branch;
    logic irq;
    logic [PC_W-1:0] target;
    logic [DA_W-2:0] file_addr;
    logic indirect;
    logic wr_en;
    logic [7:0] wr_data;
  } cfp_exec_req_t;

  // Program memory request
  typedef struct packed {
    logic rd;
    logic [PC_W-1:0] addr;
  } cfp_pmem_req_t;

endpackage

// File: hdl/cfp_phase_gen.sv
/*
  Four-phase generator: divides the input clock by four.
  Assumes reset releases synchronously enough to sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module cfp_phase_gen import cfp_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Phase outputs
  output cfp_phase_t phase_q,
  output logic rate_q
);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= CFP_PHASE_ONE;
    end else begin
      case (phase_q) // RQ1
        CFP_PHASE_ONE: phase_q <= CFP_PHASE_TWO;
        CFP_PHASE_TWO: phase_q <= CFP_PHASE_THREE;
        CFP_PHASE_THREE: phase_q <= CFP_PHASE_FOUR;
        default: phase_q <= CFP_PHASE_ONE;
      endcase
    end
  end

  // High across phase_three and phase_four: a quarter-rate square wave
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rate_q <= 1'b0;
    end else begin
      rate_q <= (phase_q == CFP_PHASE_TWO) || (phase_q == CFP_PHASE_THREE); // RQ16
    end
  end

endmodule // cfp_phase_gen
`default_nettype wire

// File: hdl/cfp_core_seq.sv
/*
  Core sequencer: phases, program counter, fetch/execute pipeline with flush,
  bank selection and general-purpose data file with core registers.
  Assumes program memory answers combinationally to pmem_q.addr, and that
  the decode logic drives exec_req stable across an instruction cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module cfp_core_seq import cfp_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Configuration
  input wire cfp_variant_t variant,
  input wire logic rc_mode,
  // Program memory
  output cfp_pmem_req_t pmem_q,
  input wire logic [INSN_W-1:0] pmem_rdata,
  // Decode and execute
  input wire cfp_exec_req_t exec_req,
  output logic [INSN_W-1:0] instruction_latch_q,
  output logic insn_valid_q,
  output logic [7:0] operand_q,
  output logic [PC_W-1:0] pc_q,
  output logic [7:0] core_flags_q,
  output logic [7:0] indirect_pointer_q,
  // Phases
  output logic [3:0] phase_onehot_q,
  output logic instruction_rate_out
);

  cfp_phase_t phase;
  logic rate;
  logic [INSN_W-1:0] fetch_q;
  logic fetch_valid_q;
  logic [7:0] pc_upper_latch_q;
  logic [7:0] gp_mem [GP_DEPTH];
  logic [PC_W-1:0] pc_mask;
  logic [DA_W-1:0] daddr;
  logic [7:0] rd_val;
  logic [7:0] gp_idx;
  logic gp_hit;
  logic [FA_W-1:0] ofs;
  logic boot_q;

  cfp_phase_gen u_phase (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .phase_q(phase),
    .rate_q(rate)
  );

  always_comb begin
    case (variant) // RQ9
      CFP_V_512_80, CFP_V_512_96: pc_mask = PMEM_MASK_512;
      CFP_V_1K_80, CFP_V_1K_96: pc_mask = PMEM_MASK_1K;
      default: pc_mask = PMEM_MASK_2K;
    endcase
  end

  // Phase observation and instruction rate pin
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_onehot_q <= 4'h0;
      instruction_rate_out <= 1'b0;
    end else begin
      phase_onehot_q <= 4'h1 << phase; // RQ1
      instruction_rate_out <= rc_mode & rate; // RQ16
    end
  end

  // First phase_one after reset fetches the reset vector instead of stepping past it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      boot_q <= 1'b1;
    end else if (phase == CFP_PHASE_ONE) begin
      boot_q <= 1'b0; // RQ10
    end
  end

  // Program counter: advance at phase_one, redirect on branch or interrupt
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pc_q <= RESET_VECTOR; // RQ10
    end else if (phase == CFP_PHASE_ONE) begin
      if (boot_q) begin
        pc_q <= RESET_VECTOR; // RQ10
      end else if (insn_valid_q && exec_req.irq) begin
        pc_q <= IRQ_VECTOR & pc_mask; // RQ10
      end else if (insn_valid_q && exec_req.branch) begin
        pc_q <= exec_req.target & pc_mask; // RQ7 RQ9
      end else begin
        pc_q <= (pc_q + 13'h0001) & pc_mask; // RQ2 RQ8 RQ9
      end
    end
  end

  // Fetch address presented one phase after the increment
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pmem_q <= '0;
    end else begin
      pmem_q.rd <= (phase == CFP_PHASE_THREE);
      pmem_q.addr <= pc_q;
    end
  end

  // Fetch stage: capture word at phase_four, flush when a branch or interrupt redirects
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fetch_q <= '0;
      fetch_valid_q <= 1'b0;
    end else if (phase == CFP_PHASE_FOUR) begin
      fetch_q <= pmem_rdata; // RQ3
      fetch_valid_q <= !(insn_valid_q && (exec_req.branch || exec_req.irq)); // RQ7
    end
  end

  // Execute stage: latch fetched word at phase_one
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      instruction_latch_q <= '0;
      insn_valid_q <= 1'b0;
    end else if (phase == CFP_PHASE_ONE) begin
      instruction_latch_q <= fetch_q; // RQ4 RQ5
      insn_valid_q <= fetch_valid_q; // RQ5 RQ7
    end
  end

  // Data address: direct uses bank_select_bit, indirect uses full pointer
  always_comb begin
    if (exec_req.indirect || exec_req.file_addr == OFS_INDIRECT_PORT) begin
      daddr = indirect_pointer_q; // RQ15
    end else begin
      daddr = {core_flags_q[BANK_SEL_BIT], exec_req.file_addr}; // RQ11
    end
    ofs = daddr[FA_W-1:0];
  end

  // Map a data address onto the general file, honoring variant limits
  always_comb begin
    gp_hit = 1'b0;
    gp_idx = ZERO8;
    if (ofs > SFR_TOP) begin // RQ12
      if (!daddr[7]) begin
        case (variant) // RQ13 RQ15
          CFP_V_512_80, CFP_V_1K_80: gp_hit = (daddr <= SMALL_TOP);
          default: gp_hit = (daddr <= MID_TOP);
        endcase
        gp_idx = daddr - GP0_LO;
      end else if (daddr >= COMMON_LO && variant != CFP_V_512_80 && variant != CFP_V_1K_80
                   && variant != CFP_V_2K_128) begin
        gp_hit = 1'b1; // RQ14
        gp_idx = daddr - COMMON_LO + (GP_PLAIN_TOP - GP0_LO + 8'h01);
      end else if ((variant == CFP_V_2K_128 || variant == CFP_V_2K_128C)
                   && daddr >= GP1_LO && daddr <= GP1_HI) begin
        gp_hit = 1'b1; // RQ13
        gp_idx = daddr - GP1_LO + (GP0_HI - GP0_LO + 8'h01);
      end
    end
  end

  // Read mux; core registers decoded on bank offset only
  always_comb begin
    if (gp_hit) begin
      rd_val = gp_mem[gp_idx];
    end else if (ofs == OFS_PC_LOW) begin // RQ18
      rd_val = pc_q[7:0];
    end else if (ofs == OFS_CORE_FLAGS) begin // RQ18
      rd_val = core_flags_q;
    end else if (ofs == OFS_INDIRECT_PTR) begin // RQ18
      rd_val = indirect_pointer_q;
    end else if (ofs == OFS_PC_UPPER_LATCH) begin // RQ18
      rd_val = pc_upper_latch_q;
    end else begin
      rd_val = ZERO8; // RQ17
    end
  end

  // Operand read at phase_two
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      operand_q <= ZERO8;
    end else if (phase == CFP_PHASE_TWO && insn_valid_q) begin
      operand_q <= rd_val; // RQ6
    end
  end

  // General file write at phase_four
  always_ff @(posedge sys_clk) begin
    if (phase == CFP_PHASE_FOUR && insn_valid_q && exec_req.wr_en && gp_hit) begin
      gp_mem[gp_idx] <= exec_req.wr_data; // RQ6 RQ17
    end
  end

  // Core register writes at phase_four
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      core_flags_q <= FLAGS_RESET;
      indirect_pointer_q <= ZERO8;
      pc_upper_latch_q <= ZERO8;
    end else if (phase == CFP_PHASE_FOUR && insn_valid_q && exec_req.wr_en && !gp_hit) begin
      if (ofs == OFS_CORE_FLAGS) begin // RQ18
        core_flags_q <= exec_req.wr_data;
      end else if (ofs == OFS_INDIRECT_PTR) begin // RQ18
        indirect_pointer_q <= exec_req.wr_data;
      end else if (ofs == OFS_PC_UPPER_LATCH) begin // RQ18
        pc_upper_latch_q <= exec_req.wr_data;
      end
    end
  end

endmodule // cfp_core_seq
`default_nettype wire

// File: dv/cfp_pmem_model.sv
/* Program memory model: a fixed word per address.
   Assumes the sequencer samples the word at its phase_four edge. */
`timescale 1ns/1ns
`default_nettype none
module cfp_pmem_model import cfp_pkg::*; (
  // Request and word
  input wire cfp_pmem_req_t pmem_q,
  output logic [INSN_W-1:0] pmem_rdata
);
  logic [INSN_W-1:0] w;
  assign w = {1'b1, pmem_q.addr} ^ 14'h2A5A;
  // Outside a read the line shows the inverse, never a stale word
  assign pmem_rdata = pmem_q.rd ? w : ~w;
endmodule // cfp_pmem_model
`default_nettype wire

// File: dv/cfp_core_seq_properties.sv
/* Port checker for the core sequencer.
   Assumes one clock domain and variant held steady outside reset. */
`timescale 1ns/1ns
`default_nettype none
module cfp_core_seq_properties import cfp_pkg::*; (
  // Clock, reset, configuration
  input wire logic sys_clk,
  input wire logic nrst,
  input wire cfp_variant_t variant,
  input wire logic rc_mode,
  // Program memory and execute
  input wire cfp_pmem_req_t pmem_q,
  input wire cfp_exec_req_t exec_req,
  input wire logic [INSN_W-1:0] instruction_latch_q,
  input wire logic insn_valid_q,
  input wire logic [PC_W-1:0] pc_q,
  // Phases
  input wire logic [3:0] phase_onehot_q,
  input wire logic instruction_rate_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [PC_W-1:0] msk;
  logic jump;
  assign msk = variant inside {CFP_V_512_80, CFP_V_512_96} ? PMEM_MASK_512 :
    variant inside {CFP_V_1K_80, CFP_V_1K_96} ? PMEM_MASK_1K : PMEM_MASK_2K;
  assign jump = insn_valid_q && (exec_req.branch || exec_req.irq);
  phase_ring_a: assert property (
    phase_onehot_q[0] |=> phase_onehot_q[1] ##1 phase_onehot_q[2] ##1 phase_onehot_q[3] ##1 phase_onehot_q[0])
    else $error("phase order broken");
  pc_on_phase_a: assert property ($changed(pc_q) |-> phase_onehot_q[0]) else $error("pc moved off phase one");
  fetch_once_a: assert property (
    pmem_q.rd |=> !pmem_q.rd [*3] ##1 pmem_q.rd) else $error("fetch not once per cycle");
  fetch_addr_a: assert property (pmem_q.rd |-> pmem_q.addr == pc_q) else $error("fetch address wrong");
  fetch_wrap_a: assert property ((pmem_q.addr & ~msk) == 0) else $error("fetch beyond memory");
  pc_step_a: assert property (
    phase_onehot_q[0] && $past(phase_onehot_q[3]) && !$past(jump) |-> pc_q == (($past(pc_q) + 13'h1) & msk))
    else $error("pc step wrong");
  boot_pc_a: assert property (
    phase_onehot_q[0] && !$past(phase_onehot_q[3]) |-> pc_q == RESET_VECTOR && !insn_valid_q)
    else $error("first fetch not at reset vector");
  jump_pc_a: assert property (
    phase_onehot_q[0] && $past(jump) |-> pc_q == ($past(exec_req.irq) ? IRQ_VECTOR : $past(exec_req.target) & msk))
    else $error("jump target wrong");
  flush_a: assert property (
    phase_onehot_q[0] && $past(jump) |-> !insn_valid_q [*4] ##1 insn_valid_q) else $error("flush wrong");
  reset_pc_a: assert property (
    $rose(nrst) |-> pc_q == RESET_VECTOR && !insn_valid_q) else $error("reset start wrong");
  latch_on_phase_a: assert property ($changed(instruction_latch_q) |-> phase_onehot_q[0]) else $error("latch off phase");
  rate_a: assert property (
    rc_mode && $rose(instruction_rate_out) |=> instruction_rate_out ##1 !instruction_rate_out [*2] ##1
    instruction_rate_out) else $error("rate output wrong");
endmodule // cfp_core_seq_properties
bind cfp_core_seq cfp_core_seq_properties cfp_core_seq_properties_inst (.sys_clk, .nrst, .variant, .rc_mode,
  .pmem_q, .exec_req, .instruction_latch_q, .insn_valid_q, .pc_q, .phase_onehot_q, .instruction_rate_out);
`default_nettype wire

// File: dv/cfp_core_seq_bench.sv
/* Bench: integer model of pc, pipeline and data file against the sequencer.
   Assumes the program memory model word formula and a 50 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
module cfp_core_seq_bench import cfp_pkg::*;;
  logic sys_clk = 0;
  logic nrst = 0;
  logic rc_mode = 0;
  cfp_variant_t variant = CFP_V_512_80;
  cfp_exec_req_t exec_req = '0;
  cfp_pmem_req_t pmem_q;
  logic [INSN_W-1:0] pmem_rdata, instruction_latch_q;
  logic insn_valid_q, instruction_rate_out;
  logic [7:0] operand_q, core_flags_q, indirect_pointer_q;
  logic [PC_W-1:0] pc_q;
  logic [3:0] phase_onehot_q;
  int bad_count = 0, n_compared = 0, seed = 22688, dm[256];
  int pc, msk, vld, bank, ptr, upl, a, r;
  always #10 sys_clk = ~sys_clk;
  cfp_core_seq cfp_core_seq_inst (.sys_clk, .nrst, .variant, .rc_mode, .pmem_q, .pmem_rdata, .exec_req,
    .instruction_latch_q, .insn_valid_q, .operand_q, .pc_q, .core_flags_q, .indirect_pointer_q,
    .phase_onehot_q, .instruction_rate_out);
  cfp_pmem_model cfp_pmem_model_inst (.pmem_q, .pmem_rdata);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic int a_of(input int d);
    if (d >= 8'h20 && d <= (variant inside {CFP_V_512_80, CFP_V_1K_80} ? 8'h6F : 8'h7F)) return d;
    if (d >= 8'hA0 && d <= 8'hBF && variant inside {CFP_V_2K_128, CFP_V_2K_128C}) return d;
    if (d >= 8'hF0 && variant inside {CFP_V_512_96, CFP_V_1K_96, CFP_V_2K_128C}) return d - 8'h80;
    return -1;
  endfunction
  function automatic int rd(input int d);
    if (d % 128 == 3) return 8'h18 + bank * 32;
    if (d % 128 == 4) return ptr;
    if (d % 128 == 10) return upl;
    return a_of(d) < 0 ? 0 : dm[a_of(d)];
  endfunction
  // One instruction cycle, from just after a phase_one edge to the next
  task automatic step(input logic br, input logic irq, input logic [12:0] tg, input logic [6:0] fa,
      input logic ind, input logic we, input logic [7:0] wd);
    int d, e, p0;
    exec_req = '{br, irq, tg, fa, ind, we, wd};
    d = (ind || fa == 0) ? ptr : bank * 128 + fa;
    e = rd(d);
    p0 = pc;
    repeat (3) @(negedge sys_clk);
    chk(16'(instruction_rate_out), 16'(rc_mode));
    @(negedge sys_clk);
    if (vld && e >= 0) chk(operand_q, 16'(e));
    if (vld && we) begin
      if (d % 128 == 3) bank = wd[5];
      else if (d % 128 == 4) ptr = wd;
      else if (d % 128 == 10) upl = wd;
      else if (a_of(d) >= 0) dm[a_of(d)] = wd;
    end
    r = vld && (br || irq);
    pc = r ? (irq ? 4 : tg & msk) : (pc + 1) & msk;
    vld = !r;
    chk(16'(pc_q), 16'(pc));
    chk(16'(insn_valid_q), 16'(vld));
    if (vld) chk(16'(instruction_latch_q), 16'(((p0 | 8192) ^ 14'h2A5A) & 14'h3FFF));
    chk(16'(indirect_pointer_q), 16'(ptr));
    chk(16'(core_flags_q[5]), 16'(bank));
    chk(16'(phase_onehot_q), 16'h0001);
  endtask
  initial begin
    for (int v = 0; v < 6; v++) begin
      nrst = 0;
      variant = cfp_variant_t'(v);
      rc_mode = v[0];
      exec_req = '0;
      repeat (5) @(negedge sys_clk);
      chk(16'(pc_q), 16'h0000);
      chk(16'(core_flags_q), 16'h0018);
      nrst = 1;
      for (a = 0; a < 9 && phase_onehot_q[0] !== 1'b1; a++)
        @(negedge sys_clk);
      if (a == 9) begin
        bad_count++;
        break;
      end
      msk = (512 << (v % 3)) - 1;
      pc = 0;
      vld = 0;
      bank = 0;
      ptr = 0;
      upl = -1;
      foreach (dm[j]) dm[j] = -1;
      for (int i = 0; i < 60; i++) begin
        r = $random(seed);
        a = (r >> 8) & 127;
        if (a == 2 || a == 4 || (a == 0 && i < 2)) a += 32;
        if (i == 1) a = 4;
        step(i == 3 || (i > 4 && r[4:2] == 0), i > 4 && r[7:5] == 0, i == 3 ? 13'h1FFF : r[28:16], 7'(a),
          r[0] && i > 1, r[3] || i == 1, i == 1 ? 8'hF3 : a == 3 ? {2'b00, r[1], 5'h18} : r[31:24]);
      end
    end
    finish_test();
  end
endmodule // cfp_core_seq_bench
`default_nettype wire
